// ==== sbl_consts.svh ====
// sbl_consts.svh: numeric constants of the serial binary load/unload block
// assumes: included by the design, checker and test files by bare name
`ifndef SBL_CONSTS_SVH
`define SBL_CONSTS_SVH

`define SBL_CLK_HZ 10000000
`define SBL_TIMEOUT_S 60
`define SBL_TIMEOUT_CYC (`SBL_CLK_HZ * `SBL_TIMEOUT_S)
`define SBL_DIR_BIT 31
`define SBL_MIN_BYTES 4096
`define SBL_CHR_CR 8'h0D
`define SBL_CHR_SP 8'h20
`define SBL_CHR_RUBOUT 8'h7F
`define SBL_CHR_ABORT 8'h03
`define SBL_CHR_PAUSE 8'h13
`define SBL_CHR_RESUME 8'h11
`define SBL_CHR_SUPPRESS 8'h0F
`define SBL_CMD_LETTER 8'h58
`define SBL_TX_PROMPT 2'h0
`define SBL_TX_ERROR 2'h1
`define SBL_TX_DATA 2'h2

`endif

// ==== sbl_pkg.sv ====
// sbl_pkg.sv: types shared by the serial binary load/unload block
// assumes: constants come from sbl_consts.svh
package sbl_pkg;
	typedef enum logic [3:0] {
		SBL_IDLE, SBL_ADDR, SBL_CNT, SBL_CKS, SBL_PROMPT, SBL_LOAD,
		SBL_LCKS, SBL_UNRD, SBL_UNWAIT, SBL_UNTX, SBL_UNCKS, SBL_ERR,
		SBL_DONE
	} sbl_state_t;

	// one memory request toward the host memory
	typedef struct packed {
		logic req;
		logic wr;
		logic [31:0] addr;
		logic [7:0] wdata;
	} sbl_mem_req_t;

	// one character or message request toward the serial transmitter
	typedef struct packed {
		logic req;
		logic [1:0] kind;
		logic [7:0] data;
	} sbl_tx_req_t;
endpackage

// ==== sbl_timer.sv ====
// sbl_timer.sv: idle timeout counter for the transfer
// assumes: clk, restart and run synchronous to one clock
`timescale 1ns/1ns
`include "sbl_consts.svh"
module sbl_timer #(
	parameter int unsigned LIMIT = `SBL_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic run,
	input wire logic restart,
	output logic expired
);
	logic [29:0] count;
	logic [29:0] next_count;
	logic next_expired;

	// counts system clocks, so the limit does not depend on baud rate
	always_comb begin
		next_count = count;
		next_expired = 1'b0;
		if (!run || restart) begin // see (RULE16)
			next_count = '0;
		end else if (count >= 30'(LIMIT - 1)) begin
			next_expired = 1'b1;
			next_count = '0;
		end else begin
			next_count = count + 30'h1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count <= '0;
			expired <= 1'b0;
		end else begin
			count <= next_count;
			expired <= next_expired;
		end
	end
endmodule

// ==== sbl_ctrl.sv ====
// sbl_ctrl.sv: interpreter for the binary load/unload console command
// assumes: a receiver hands over one byte per rx_valid pulse; a transmitter
// accepts tx requests and answers tx_done; memory answers mem_ack.
//
// Functional notes
// (RULE1) count top bit picks load or unload
// (RULE2) lower count bits give byte total
// (RULE3) one unechoed checksum byte after CR
// (RULE4) command bytes sum modulo 256 to zero
// (RULE5) good checksum prompts; bad one reports error
// (RULE6) load data plus checksum must sum zero
// (RULE7) unload sends bytes then negated sum
// (RULE8) errors reported only after full count
// (RULE9) no echo during data and checksums
// (RULE10) flow control stops at command CR
// (RULE11) controls honoured in unload, not load
// (RULE12) requester gaps between load bytes bounded
// (RULE13) requester checksums within the time limit
// (RULE14) timeout abandons transfer with error
// (RULE15) keeps up with back-to-back bytes, 4 KB
// (RULE16) timeout from system clock, restarted per byte
`timescale 1ns/1ns
`include "sbl_consts.svh"
module sbl_ctrl
	import sbl_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = `SBL_TIMEOUT_CYC,
	parameter int unsigned CNT_W = 31
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_error,
	input wire logic tx_done,
	input wire logic mem_ack,
	input wire logic mem_error,
	input wire logic [7:0] mem_rdata,
	output sbl_tx_req_t tx,
	output logic echo_en,
	output logic flow_en,
	output sbl_mem_req_t mem,
	output logic busy
);
	sbl_state_t state, next_state;
	logic [31:0] addr, next_addr;
	logic [31:0] cnt, next_cnt;
	logic [7:0] sum, next_sum;
	logic [7:0] ch, next_ch;
	logic dir_unload, next_dir_unload;
	logic fail, next_fail;
	logic paused, next_paused;
	logic quiet, next_quiet;
	logic next_echo, next_flow;
	sbl_tx_req_t next_tx;
	sbl_mem_req_t next_mem;
	logic timer_run, timed_out;

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic is_hex(input logic [7:0] c);
		return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) ||
			(c >= 8'h61 && c <= 8'h66);
	endfunction

	function automatic logic [31:0] hex_shift(input logic [31:0] v,
		input logic [7:0] c);
		logic [3:0] d;
		d = (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'h9);
		return {v[27:0], d};
	endfunction

	// timer only runs where the requester is bound by a time limit
	assign timer_run = (state == SBL_CKS) || (state == SBL_LOAD) ||
		(state == SBL_LCKS);

	sbl_timer #(.LIMIT(TIMEOUT_CYC)) u_timer (
		.clk(clk),
		.resetn(resetn),
		.run(timer_run),
		.restart(rx_valid), // see (RULE16)
		.expired(timed_out)
	);

	// --------------------------------------------------------------
	// command state machine
	// --------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_addr = addr;
		next_cnt = cnt;
		next_sum = sum;
		next_ch = ch;
		next_dir_unload = dir_unload;
		next_fail = fail;
		next_paused = paused;
		next_quiet = quiet;
		next_echo = echo_en;
		next_flow = flow_en;
		next_tx = '0;
		next_mem = mem;
		next_mem.req = 1'b0;
		case (state)
		SBL_IDLE: begin
			next_echo = 1'b1;
			next_flow = 1'b1;
			// command letter counts toward the line sum
			if (rx_valid && (rx_data == `SBL_CMD_LETTER ||
				rx_data == 8'h78)) begin
				next_sum = rx_data;
				next_addr = '0;
				next_cnt = '0;
				next_fail = 1'b0;
				next_ch = 8'h00;
				next_state = SBL_ADDR;
			end
		end
		SBL_ADDR, SBL_CNT: begin
			if (rx_valid) begin
				if (rx_data == `SBL_CHR_CR) begin
					next_echo = 1'b0; // see (RULE3) (RULE9)
					next_flow = 1'b0; // see (RULE10)
					next_state = SBL_CKS;
				end else if (rx_data == `SBL_CHR_RUBOUT) begin
					// rubout drops the command; echoed line restarts
					next_state = SBL_IDLE;
				end else begin
					next_sum = 8'(sum + rx_data); // see (RULE4)
					if (rx_data == `SBL_CHR_SP) begin
						if (state == SBL_ADDR && addr != '0 ||
							state == SBL_ADDR && ch != 8'h00)
							next_state = SBL_CNT;
					end else if (is_hex(rx_data)) begin
						if (state == SBL_ADDR)
							next_addr = hex_shift(addr, rx_data);
						else
							next_cnt = hex_shift(cnt, rx_data);
					end
					next_ch = rx_data;
				end
			end
		end
		SBL_CKS: begin
			if (timed_out) begin
				next_state = SBL_ERR; // see (RULE14)
			end else if (rx_valid) begin
				next_dir_unload = cnt[`SBL_DIR_BIT]; // see (RULE1)
				next_cnt = {1'b0, cnt[CNT_W-1:0]}; // see (RULE2)
				next_sum = '0;
				next_paused = 1'b0;
				next_quiet = 1'b0;
				if (8'(sum + rx_data) == 8'h00) // see (RULE4) (RULE5)
					next_state = SBL_PROMPT;
				else
					next_state = SBL_ERR;
			end
		end
		SBL_PROMPT: begin
			next_tx.req = !tx_done;
			next_tx.kind = `SBL_TX_PROMPT; // see (RULE5)
			if (tx_done) begin
				next_flow = dir_unload; // see (RULE11)
				if (dir_unload)
					next_state = SBL_UNRD;
				else if (cnt == '0)
					next_state = SBL_LCKS;
				else
					next_state = SBL_LOAD;
			end
		end
		SBL_LOAD: begin
			// all bytes are data here; no control decoding
			if (mem_error || rx_error)
				next_fail = 1'b1; // see (RULE8)
			if (timed_out) begin
				next_state = SBL_ERR; // see (RULE14)
			end else if (rx_valid) begin // see (RULE15) (RULE11)
				next_mem.req = 1'b1;
				next_mem.wr = 1'b1;
				next_mem.addr = addr;
				next_mem.wdata = rx_data;
				next_addr = addr + 32'h1; // see (RULE2)
				next_sum = 8'(sum + rx_data); // see (RULE6)
				next_cnt = cnt - 32'h1;
				if (cnt == 32'h1)
					next_state = SBL_LCKS;
			end
		end
		SBL_LCKS: begin
			if (mem_error || rx_error)
				next_fail = 1'b1;
			if (timed_out) begin
				next_state = SBL_ERR; // see (RULE14)
			end else if (rx_valid) begin
				if (8'(sum + rx_data) != 8'h00 || fail) // see (RULE6) (RULE8)
					next_state = SBL_ERR;
				else
					next_state = SBL_DONE;
			end
		end
		SBL_UNRD: begin
			if (cnt == '0 || !dir_unload) begin
				next_state = dir_unload ? SBL_UNCKS : SBL_DONE;
			end else if (!paused) begin
				next_mem.req = 1'b1;
				next_mem.wr = 1'b0;
				next_mem.addr = addr;
				next_state = SBL_UNWAIT;
			end
		end
		SBL_UNWAIT: begin
			if (mem_error)
				next_fail = 1'b1; // see (RULE8)
			if (mem_ack) begin
				next_ch = mem_rdata;
				next_sum = 8'(sum + mem_rdata); // see (RULE7)
				next_state = SBL_UNTX;
			end
		end
		SBL_UNTX: begin
			// suppressed output still walks memory and the sum
			next_tx.req = (tx.req || !quiet) && !tx_done;
			next_tx.kind = `SBL_TX_DATA;
			next_tx.data = ch;
			if (tx_done || (quiet && !tx.req)) begin
				next_addr = addr + 32'h1;
				next_cnt = cnt - 32'h1;
				next_state = SBL_UNRD;
			end
		end
		SBL_UNCKS: begin
			next_tx.req = !tx_done;
			next_tx.kind = `SBL_TX_DATA;
			next_tx.data = 8'(8'h00 - sum); // see (RULE7)
			if (tx_done)
				next_state = fail ? SBL_ERR : SBL_DONE; // see (RULE8)
		end
		SBL_ERR: begin
			next_tx.req = !tx_done;
			next_tx.kind = `SBL_TX_ERROR; // see (RULE5) (RULE14)
			if (tx_done)
				next_state = SBL_DONE;
		end
		SBL_DONE: begin
			next_echo = 1'b1;
			next_flow = 1'b1;
			next_state = SBL_IDLE;
		end
		default: begin
			next_state = SBL_IDLE;
		end
		endcase
		// unload honours abort, pause and suppress from the line
		if (dir_unload && rx_valid && (state == SBL_UNRD ||
			state == SBL_UNWAIT || state == SBL_UNTX)) begin // see (RULE11)
			if (rx_data == `SBL_CHR_ABORT && state == SBL_UNTX)
				next_dir_unload = 1'b0; // byte on the wire ends first
			else if (rx_data == `SBL_CHR_ABORT)
				next_state = SBL_DONE;
			else if (rx_data == `SBL_CHR_PAUSE)
				next_paused = 1'b1;
			else if (rx_data == `SBL_CHR_RESUME)
				next_paused = 1'b0;
			else if (rx_data == `SBL_CHR_SUPPRESS)
				next_quiet = !quiet;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= SBL_IDLE;
			addr <= '0;
			cnt <= '0;
			sum <= '0;
			ch <= '0;
			dir_unload <= 1'b0;
			fail <= 1'b0;
			paused <= 1'b0;
			quiet <= 1'b0;
			echo_en <= 1'b1;
			flow_en <= 1'b1;
			tx <= '0;
			mem <= '0;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			addr <= next_addr;
			cnt <= next_cnt;
			sum <= next_sum;
			ch <= next_ch;
			dir_unload <= next_dir_unload;
			fail <= next_fail;
			paused <= next_paused;
			quiet <= next_quiet;
			echo_en <= next_echo;
			flow_en <= next_flow;
			tx <= next_tx;
			mem <= next_mem;
			busy <= (next_state != SBL_IDLE);
		end
	end
endmodule

// ==== sbl_ctrl_props.sv ====
// sbl_ctrl_props.sv: port checker for sbl_ctrl
// assumes: bound to every sbl_ctrl, one clock domain
`timescale 1ns/1ns
`include "sbl_consts.svh"
module sbl_ctrl_props
	import sbl_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = `SBL_TIMEOUT_CYC,
	parameter int unsigned CNT_W = 31
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_error,
	input wire logic tx_done,
	input wire logic mem_ack,
	input wire logic mem_error,
	input wire logic [7:0] mem_rdata,
	input wire sbl_tx_req_t tx,
	input wire logic echo_en,
	input wire logic flow_en,
	input wire sbl_mem_req_t mem,
	input wire logic busy
);
	// silent cycles while a transfer waits on the requester
	int unsigned quiet;
	int unsigned next_quiet;
	always_comb begin
		next_quiet = 0;
		if (busy && !echo_en && !tx.req && !rx_valid)
			next_quiet = quiet + 1;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			quiet <= 0;
		else
			quiet <= next_quiet;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	AST_IDLE_QUIET: assert property (
		!busy |-> echo_en && flow_en && !mem.req)
		else $error("idle with echo, flow or memory wrong");
	AST_WR_DATA: assert property (
		mem.req && mem.wr |-> $past(rx_valid) && mem.wdata == $past(rx_data))
		else $error("write not taken from last byte");
	AST_WR_NOECHO: assert property (
		mem.req && mem.wr |-> !echo_en && !flow_en)
		else $error("echo or flow on during load");
	AST_RD_NOECHO: assert property (
		mem.req && !mem.wr |-> !echo_en)
		else $error("echo on during unload read");
	AST_TX_NOECHO: assert property (
		tx.req && tx.kind == `SBL_TX_DATA |-> !echo_en)
		else $error("echo on while sending data");
	AST_TX_HOLD: assert property (
		tx.req && !tx_done |=> tx.req && $stable(tx))
		else $error("send request changed before done");
	AST_TX_DROP: assert property (
		tx.req && tx_done |=> !tx.req)
		else $error("send request held after done");
	AST_TIMER: assert property (
		quiet <= TIMEOUT_CYC + 3)
		else $error("no timeout error after idle limit");
	cover property (mem.req && mem.wr);
	cover property (tx.req && tx.kind == `SBL_TX_ERROR);
	cover property (tx.req && tx.kind == `SBL_TX_DATA && tx_done);
endmodule
bind sbl_ctrl sbl_ctrl_props #(.TIMEOUT_CYC(TIMEOUT_CYC), .CNT_W(CNT_W))
	i_sbl_ctrl_props (.clk(clk), .resetn(resetn), .rx_valid(rx_valid),
	.rx_data(rx_data), .rx_error(rx_error), .tx_done(tx_done),
	.mem_ack(mem_ack), .mem_error(mem_error), .mem_rdata(mem_rdata),
	.tx(tx), .echo_en(echo_en), .flow_en(flow_en), .mem(mem), .busy(busy));

// ==== sbl_host_model.sv ====
// sbl_host_model.sv: memory and transmitter beside sbl_ctrl
// assumes: delay sets how many cycles each answer takes
`timescale 1ns/1ns
module sbl_host_model
	import sbl_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] delay,
	input wire sbl_tx_req_t tx,
	input wire sbl_mem_req_t mem,
	output logic tx_done,
	output logic mem_ack,
	output logic [7:0] mem_rdata
);
	logic [7:0] store [4096];
	logic [3:0] tx_wait;
	logic [3:0] rd_wait;
	logic rd_pend;
	logic [11:0] rd_addr;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{tx_wait, rd_wait, rd_pend, tx_done, mem_ack} <= '0;
			mem_rdata <= 8'hA5;
		end else begin
			tx_done <= 1'b0;
			mem_ack <= 1'b0;
			// released data toggles so stale bytes never pass
			mem_rdata <= ~mem_rdata;
			if (tx.req && !tx_done) begin
				tx_wait <= tx_wait + 4'h1;
				if (tx_wait == delay) begin
					tx_done <= 1'b1;
					tx_wait <= 4'h0;
				end
			end
			if (mem.req && mem.wr)
				store[mem.addr[11:0]] <= mem.wdata;
			if (mem.req && !mem.wr) begin
				rd_pend <= 1'b1;
				rd_addr <= mem.addr[11:0];
				rd_wait <= 4'h0;
			end else if (rd_pend) begin
				rd_wait <= rd_wait + 4'h1;
				if (rd_wait == delay) begin
					mem_ack <= 1'b1;
					mem_rdata <= store[rd_addr];
					rd_pend <= 1'b0;
				end
			end
		end
	end
endmodule

// ==== sbl_ctrl_test.sv ====
// sbl_ctrl_test.sv: self-checking bench for sbl_ctrl
// assumes: sbl_host_model answers memory and transmitter
`timescale 1ns/1ns
`include "sbl_consts.svh"
module sbl_ctrl_test;
	import sbl_pkg::*;
	logic clk = 0, resetn = 0, rx_valid = 0, rx_error = 0, mem_error = 0;
	logic [7:0] rx_data = 8'h00;
	logic [3:0] delay = 4'h0;
	logic tx_done, mem_ack, echo_en, flow_en, busy;
	logic [7:0] mem_rdata;
	sbl_tx_req_t tx;
	sbl_mem_req_t mem;
	logic [7:0] q[$], d[$];
	logic [9:0] txlog[$], e[$];
	int fail_count = 0, num_checks = 0, wr_n = 0;
	always #50 clk = ~clk;
	sbl_ctrl #(.TIMEOUT_CYC(50)) i_sbl_ctrl (.clk(clk), .resetn(resetn),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
		.tx_done(tx_done), .mem_ack(mem_ack), .mem_error(mem_error),
		.mem_rdata(mem_rdata), .tx(tx), .echo_en(echo_en),
		.flow_en(flow_en), .mem(mem), .busy(busy));
	sbl_host_model i_sbl_host_model (.clk(clk), .resetn(resetn),
		.delay(delay), .tx(tx), .mem(mem), .tx_done(tx_done),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	// bytes leave back to back, far inside the idle limit
	always @(negedge clk) begin
		rx_valid <= q.size() != 0;
		if (q.size() != 0)
			rx_data <= q.pop_front();
	end
	always @(posedge clk) begin
		if (tx.req && tx_done)
			txlog.push_back({tx.kind, tx.kind == 2 ? tx.data : 8'h00});
		if (mem.req && mem.wr)
			wr_n++;
	end
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmd(string s, bit bad);
		logic [7:0] sum;
		sum = 8'h00;
		wr_n = 0;
		for (int i = 0; i < s.len(); i++) begin
			q.push_back(s[i]);
			sum += s[i];
		end
		q.push_back(`SBL_CHR_CR);
		q.push_back(8'(bad) - sum);
	endtask
	task automatic data(bit bad);
		logic [7:0] sum;
		sum = 8'h00;
		foreach (d[i]) begin
			q.push_back(d[i]);
			sum += d[i];
		end
		q.push_back(8'(bad) - sum);
	endtask
	task automatic wait_log(int n);
		for (int k = 0; k < 3000 && txlog.size() < n; k++)
			@(negedge clk);
		chk("prompt wait", 1, txlog.size() >= n);
	endtask
	task automatic expect_log(string what);
		for (int k = 0; k < 3000 && (q.size() || busy !== 1'b0); k++)
			@(negedge clk);
		chk({what, " idle"}, 0, busy);
		chk({what, " count"}, e.size(), txlog.size());
		foreach (e[i])
			if (i < txlog.size())
				chk(what, e[i], txlog[i]);
		txlog.delete();
		$display("test %s finished", what);
	endtask
	task automatic t_load;
		cmd("X1000 3", 0);
		wait_log(1);
		d = '{8'h03, 8'h13, 8'h0F};
		data(0);
		e = '{10'h000};
		expect_log("load");
		chk("writes", 3, wr_n);
		foreach (d[i])
			chk("stored", d[i], i_sbl_host_model.store[i]);
	endtask
	task automatic t_bad_cmd;
		cmd("X1000 2", 1);
		e = '{10'h100};
		expect_log("bad command");
		chk("writes", 0, wr_n);
	endtask
	task automatic t_unload;
		delay = 4'h2;
		cmd("X1000 80000003", 0);
		e = '{10'h000, 10'h203, 10'h213, 10'h20F, 10'h2DB};
		expect_log("unload");
		delay = 4'h0;
	endtask
	// abort lands before the first byte leaves: prompt only
	task automatic t_abort;
		cmd("X1000 80000003", 0);
		wait_log(1);
		q.push_back(`SBL_CHR_ABORT);
		e = '{10'h000};
		expect_log("abort");
	endtask
	// suppressed bytes still count toward the closing sum
	task automatic t_quiet;
		cmd("X1000 80000003", 0);
		wait_log(1);
		q = '{`SBL_CHR_PAUSE, `SBL_CHR_SUPPRESS, `SBL_CHR_RESUME};
		e = '{10'h000, 10'h2DB};
		expect_log("suppressed unload");
	endtask
	// a bad sum, a line or a memory error still takes the whole count
	task automatic t_fail(int k);
		cmd("X1008 2", 0);
		wait_log(1);
		d = '{8'h5A, 8'hC3};
		data(k == 0);
		@(negedge clk);
		rx_error = k == 1;
		mem_error = k == 2;
		@(negedge clk);
		rx_error = 0;
		mem_error = 0;
		e = '{10'h000, 10'h100};
		expect_log("failed load");
		chk("writes", 2, wr_n);
	endtask
	task automatic t_timeout;
		cmd("X1000 3", 0);
		e = '{10'h000, 10'h100};
		expect_log("timeout");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#4000000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		repeat (12) @(negedge clk);
		chk("reset outputs", 3'b110, {echo_en, flow_en, busy});
		resetn = 1;
		t_load();
		t_bad_cmd();
		t_unload();
		t_abort();
		t_quiet();
		t_fail(0);
		t_fail(1);
		t_fail(2);
		t_timeout();
		tally_and_finish();
	end
endmodule
